// File: rtl/persist_filter.sv
`default_nettype none
module persist_filter #(
	parameter int unsigned HOLD_CYCLES = pg_diag_pkg::LIMIT_PERSIST_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// condition and its persisted copy
	input  wire logic level,
	output logic      persisted
);
	// needs HOLD_CYCLES of at least 2
	localparam int unsigned      CNT_W = $clog2(HOLD_CYCLES);
	localparam logic [CNT_W-1:0] LAST  = CNT_W'(HOLD_CYCLES - 1);

	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q     <= '0;
			persisted <= 1'b0;
		end
		else if (ce)
		begin
			if (!level)
			begin
				cnt_q     <= '0;
				persisted <= 1'b0;
			end
			else if (cnt_q != LAST)
				cnt_q <= cnt_q + 1'b1;
			else
				persisted <= 1'b1;
		end
	end

	a_drop_clears: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		!level |=> !persisted)
		else $error("persisted flag outlived its condition");

	a_persist_counted: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		$rose(persisted) |-> ($past(cnt_q) == LAST) && $past(level))
		else $error("persisted flag rose before the full run");
endmodule
`default_nettype wire

// File: rtl/pg_diag_pkg.sv
`default_nettype none
package pg_diag_pkg;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_MHZ                = 100;
	localparam int unsigned LIMIT_PERSIST_US       = 20;
	localparam int unsigned LIMIT_PERSIST_CYCLES   = (LIMIT_PERSIST_US * CLK_MHZ > 0) ?
		LIMIT_PERSIST_US * CLK_MHZ : 1;
	localparam int unsigned HOLDOFF_US             = 800;
	localparam int unsigned HOLDOFF_DEFAULT_CYCLES = HOLDOFF_US * CLK_MHZ;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int unsigned NUM_BUCK   = 2;
	localparam int unsigned NUM_LIN    = 2;
	localparam int unsigned NUM_RAILS  = NUM_BUCK + NUM_LIN;
	localparam int unsigned ILIM_W     = 3;
	localparam int unsigned ILIM_STEP  = 4;
	localparam int unsigned AXI_ADDR_W = 8;

	// ****************************************************************
	// register offsets (byte addresses)
	// ****************************************************************
	localparam logic [AXI_ADDR_W-1:0] OFS_PG_CTRL_A = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] OFS_PG_CTRL_B = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] OFS_ILIM      = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] OFS_FAULT     = 8'h0C;
	localparam logic [AXI_ADDR_W-1:0] OFS_INT       = 8'h10;
	localparam logic [AXI_ADDR_W-1:0] OFS_MASK      = 8'h14;
	localparam logic [AXI_ADDR_W-1:0] OFS_STAT     = 8'h18;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// field layouts
	// ****************************************************************
	typedef struct packed {
		logic                 pg_pin_open_drain;
		logic                 pg_pin_polarity;
		logic [NUM_RAILS-1:0] rail_window_check_select;
		logic [NUM_LIN-1:0]   linear_rail_pg_select;
		logic [NUM_BUCK-1:0]  buck_rail_pg_select;
	} pg_ctrl_a_t;

	typedef struct packed {
		logic thermal_warn_threshold_sel;
		logic fault_holds_pg_inactive;
		logic pg_operating_mode;
		logic thermal_warn_pg_select;
	} pg_ctrl_b_t;

	typedef struct packed {
		logic                thermal_shutdown_irq_flag;
		logic                overvoltage_irq_flag;
		logic                thermal_warn_irq_flag;
		logic [NUM_LIN-1:0]  linear_limit_irq_flag;
		logic [NUM_BUCK-1:0] buck_limit_irq_flag;
	} irq_t;

	// ****************************************************************
	// reset values and mode codes
	// ****************************************************************
	localparam pg_ctrl_a_t          PG_CTRL_A_RST = 10'h100;
	localparam pg_ctrl_b_t          PG_CTRL_B_RST = 4'h0;
	localparam logic [ILIM_W-1:0]   ILIM_RST      = 3'h0;
	localparam irq_t                MASK_RST      = 7'h00;
	localparam logic                MODE_GATED    = 1'b0;
	localparam logic                MODE_CONT     = 1'b1;
endpackage
`default_nettype wire

// File: rtl/power_good_and_diag_monitor.sv
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`default_nettype none
module power_good_and_diag_monitor #(
	parameter int unsigned HOLDOFF_CYCLES = pg_diag_pkg::HOLDOFF_DEFAULT_CYCLES
) (
	// clock, enable, reset
	input  wire logic                                     clk,
	input  wire logic                                     ce,
	input  wire logic                                     rst_n,
	// axi4-lite write
	input  wire logic [pg_diag_pkg::AXI_ADDR_W-1:0]       awaddr,
	input  wire logic                                     awvalid,
	output logic                                          awready,
	input  wire logic [31:0]                              wdata,
	input  wire logic [3:0]                               wstrb,
	input  wire logic                                     wvalid,
	output logic                                          wready,
	output logic [1:0]                                    bresp,
	output logic                                          bvalid,
	input  wire logic                                     bready,
	// axi4-lite read
	input  wire logic [pg_diag_pkg::AXI_ADDR_W-1:0]       araddr,
	input  wire logic                                     arvalid,
	output logic                                          arready,
	output logic [31:0]                                   rdata,
	output logic [1:0]                                    rresp,
	output logic                                          rvalid,
	input  wire logic                                     rready,
	// configuration load
	input  wire logic                                     otp_done,
	input  wire logic                                     otp_pg_mode,
	// rail monitors, index 0..1 buck, 2..3 linear
	input  wire logic [pg_diag_pkg::NUM_RAILS-1:0]        rail_enable,
	input  wire logic [pg_diag_pkg::NUM_RAILS-1:0]        rail_uv_ok,
	input  wire logic [pg_diag_pkg::NUM_RAILS-1:0]        rail_ov_ok,
	input  wire logic [pg_diag_pkg::NUM_RAILS-1:0]        rail_ramping,
	input  wire logic [pg_diag_pkg::NUM_RAILS-1:0]        rail_in_limit,
	// die and supply monitors
	input  wire logic                                     temp_above_warn_lo,
	input  wire logic                                     temp_above_warn_hi,
	input  wire logic                                     ovp_detect,
	input  wire logic                                     tsd_detect,
	// pins and analog settings
	output logic                                          power_good_out,
	output logic                                          power_good_oe,
	output logic                                          irq_line_n,
	output logic [pg_diag_pkg::NUM_BUCK-1:0][pg_diag_pkg::ILIM_W-1:0] buck_peak_limit_setting
);
	localparam int unsigned   NR     = pg_diag_pkg::NUM_RAILS;
	localparam int unsigned   HOLD_W = $clog2(HOLDOFF_CYCLES + 1);
	localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLDOFF_CYCLES);

	logic                       rst_meta_q;
	logic                       rst_sync_n;
	logic                       aw_have_q;
	logic                       w_have_q;
	logic [pg_diag_pkg::AXI_ADDR_W-1:0] aw_addr_q;
	logic [31:0]                w_data_q;
	logic [3:0]                 w_strb_q;
	logic [31:0]                wmask;
	logic                       do_write;
	logic                       wr_hit;
	logic [31:0]                rd_data;
	logic                       rd_err;
	pg_diag_pkg::pg_ctrl_a_t    ctrl_a_q;
	pg_diag_pkg::pg_ctrl_b_t    ctrl_b_q;
	pg_diag_pkg::irq_t          int_q;
	pg_diag_pkg::irq_t          int_d;
	pg_diag_pkg::irq_t          mask_q;
	pg_diag_pkg::irq_t          mask_d;
	pg_diag_pkg::irq_t          int_set;
	pg_diag_pkg::irq_t          int_live;
	pg_diag_pkg::irq_t          int_clr;
	logic [NR-1:0]              rail_fault_latch_reg_q;
	logic [NR-1:0]              fault_set;
	logic [NR-1:0]              fault_clr;
	logic [NR-1:0]              limit_persist;
	logic [NR-1:0]              rail_ok;
	logic [NR-1:0]              rail_sel;
	logic [NR-1:0]              rail_bad;
	logic [NR-1:0]              ramp_en;
	logic [NR-1:0]              en_prev_q;
	logic [NR-1:0]              ramp_prev_q;
	logic                       started_q;
	logic                       thermal_warn_status;
	logic                       valid_all;
	logic                       cont_mode;
	logic                       en_rise;
	logic                       hold_trig;
	logic                       freeze;
	logic [HOLD_W-1:0]          hold_cnt_q;
	logic                       pg_q;
	logic                       pg_d;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_n || !ce);

	// ****************************************************************
	// reset release
	// ****************************************************************
	// runs without ce so that a frozen block still leaves reset cleanly
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// ****************************************************************
	// axi4-lite slave
	// ****************************************************************
	assign do_write = aw_have_q && w_have_q && !bvalid;
	assign wmask    = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign wr_hit   = aw_addr_q[7:2] inside {pg_diag_pkg::OFS_PG_CTRL_A[7:2],
		pg_diag_pkg::OFS_PG_CTRL_B[7:2], pg_diag_pkg::OFS_ILIM[7:2],
		pg_diag_pkg::OFS_FAULT[7:2], pg_diag_pkg::OFS_INT[7:2],
		pg_diag_pkg::OFS_MASK[7:2], pg_diag_pkg::OFS_STAT[7:2]};

	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			bvalid    <= 1'b0;
			bresp     <= pg_diag_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (awvalid && awready)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= awaddr;
				awready   <= 1'b0;
			end
			if (wvalid && wready)
			begin
				w_have_q <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
				wready   <= 1'b0;
			end
			if (do_write)
			begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= wr_hit ? pg_diag_pkg::RESP_OKAY : pg_diag_pkg::RESP_SLVERR;
			end
			if (bvalid && bready)
			begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_comb
	begin
		rd_data = '0;
		rd_err  = 1'b0;
		unique case (araddr[7:2])
			pg_diag_pkg::OFS_PG_CTRL_A[7:2]: rd_data[9:0] = ctrl_a_q;
			pg_diag_pkg::OFS_PG_CTRL_B[7:2]: rd_data[3:0] = ctrl_b_q;
			pg_diag_pkg::OFS_ILIM[7:2]:
			begin
				for (int i = 0; i < pg_diag_pkg::NUM_BUCK; i++)
					rd_data[i*pg_diag_pkg::ILIM_STEP +: pg_diag_pkg::ILIM_W] =
						buck_peak_limit_setting[i];
			end
			pg_diag_pkg::OFS_FAULT[7:2]:     rd_data[NR-1:0] = rail_fault_latch_reg_q;
			pg_diag_pkg::OFS_INT[7:2]:       rd_data[6:0] = int_q;
			pg_diag_pkg::OFS_MASK[7:2]:      rd_data[6:0] = mask_q;
			// live limit status, warning, supply, shutdown, power-good state, rail validity
			pg_diag_pkg::OFS_STAT[7:2]:
				rd_data[11:0] = {rail_ok, pg_q, tsd_detect, ovp_detect,
					thermal_warn_status, rail_in_limit};
			default:                         rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= pg_diag_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (arvalid && arready)
			begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rd_data;
				rresp   <= rd_err ? pg_diag_pkg::RESP_SLVERR : pg_diag_pkg::RESP_OKAY;
			end
			else if (rvalid && rready)
			begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ctrl_a_q <= pg_diag_pkg::PG_CTRL_A_RST;
			ctrl_b_q <= pg_diag_pkg::PG_CTRL_B_RST;
			mask_q   <= pg_diag_pkg::MASK_RST;
			for (int i = 0; i < pg_diag_pkg::NUM_BUCK; i++)
				buck_peak_limit_setting[i] <= pg_diag_pkg::ILIM_RST;
		end
		else if (ce)
		begin
			// the strap is caught when the load completes, not at reset
			if (otp_done && !started_q)
				ctrl_b_q.pg_operating_mode <= otp_pg_mode;
			if (do_write && aw_addr_q[7:2] == pg_diag_pkg::OFS_PG_CTRL_A[7:2])
				ctrl_a_q <= (ctrl_a_q & ~wmask[9:0]) | (w_data_q[9:0] & wmask[9:0]);
			if (do_write && aw_addr_q[7:2] == pg_diag_pkg::OFS_PG_CTRL_B[7:2])
				ctrl_b_q <= (ctrl_b_q & ~wmask[3:0]) | (w_data_q[3:0] & wmask[3:0]);
			mask_q <= mask_d;
			if (do_write && aw_addr_q[7:2] == pg_diag_pkg::OFS_ILIM[7:2] && w_strb_q[0])
			begin
				for (int i = 0; i < pg_diag_pkg::NUM_BUCK; i++)
					buck_peak_limit_setting[i] <=
						w_data_q[i*pg_diag_pkg::ILIM_STEP +: pg_diag_pkg::ILIM_W];
			end
		end
	end

	assign mask_d = (do_write && aw_addr_q[7:2] == pg_diag_pkg::OFS_MASK[7:2]) ?
		pg_diag_pkg::irq_t'((mask_q & ~wmask[6:0]) | (w_data_q[6:0] & wmask[6:0])) : mask_q;

	// ****************************************************************
	// interrupt flags
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < NR; g++)
		begin : g_limit
			persist_filter #(
				.HOLD_CYCLES (pg_diag_pkg::LIMIT_PERSIST_CYCLES)
			) u_persist (
				.clk       (clk),
				.rst_n     (rst_sync_n),
				.ce        (ce),
				.level     (rail_in_limit[g]),
				.persisted (limit_persist[g])
			);
		end
	endgenerate

	assign thermal_warn_status = ctrl_b_q.thermal_warn_threshold_sel ?
		temp_above_warn_hi : temp_above_warn_lo;
	assign int_set  = {tsd_detect, ovp_detect, thermal_warn_status, limit_persist};
	assign int_live = {tsd_detect, ovp_detect, thermal_warn_status, rail_in_limit};
	assign int_clr  = (do_write && aw_addr_q[7:2] == pg_diag_pkg::OFS_INT[7:2]) ?
		pg_diag_pkg::irq_t'(w_data_q[6:0] & wmask[6:0]) : '0;
	// a clear is ignored while its cause is live; a new set wins over a clear
	assign int_d = (int_q & ~(int_clr & ~int_live)) | int_set;

	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			int_q <= '0;
		else if (ce)
			int_q <= int_d;
	end

	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			irq_line_n <= 1'b1;
		else if (ce)
			irq_line_n <= ~|(int_d & ~mask_d);
	end

	a_irq_line_match: assert property (
		1'b1 |=> irq_line_n == !(|(int_q & ~mask_q)))
		else $error("interrupt line disagrees with unmasked flags");

	a_limit_sets_flag: assert property (
		limit_persist[0] |=> int_q.buck_limit_irq_flag[0])
		else $error("persistent buck limit did not set its flag");

	a_clear_refused: assert property (
		int_q.linear_limit_irq_flag[0] && rail_in_limit[2] |=> int_q.linear_limit_irq_flag[0])
		else $error("limit flag cleared while still limiting");

	a_warn_clear_held: assert property (
		int_q.thermal_warn_irq_flag && thermal_warn_status |=> int_q.thermal_warn_irq_flag)
		else $error("thermal warning flag cleared while hot");

	// ****************************************************************
	// rail monitoring and fault latches
	// ****************************************************************
	assign rail_ok   = rail_uv_ok & (~ctrl_a_q.rail_window_check_select | rail_ov_ok);
	assign rail_sel  = {ctrl_a_q.linear_rail_pg_select, ctrl_a_q.buck_rail_pg_select};
	assign rail_bad  = rail_sel & rail_enable & ~rail_ok;
	assign ramp_en   = rail_ramping & rail_enable;
	assign cont_mode = ctrl_b_q.pg_operating_mode == pg_diag_pkg::MODE_CONT;
	assign valid_all = !(|rail_bad) && !(ctrl_b_q.thermal_warn_pg_select && thermal_warn_status)
		&& !int_q.overvoltage_irq_flag && !int_q.thermal_shutdown_irq_flag;
	assign en_rise   = |(rail_enable & ~en_prev_q);
	assign hold_trig = en_rise || (|(ramp_en & ~ramp_prev_q));
	assign freeze    = !cont_mode && (hold_cnt_q != '0 || hold_trig);
	// faults are not taken while the hold-off or a ramp masks the rail
	assign fault_set = rail_bad & {NR{started_q}} &
		(cont_mode ? ~ramp_en : {NR{!freeze}});
	assign fault_clr = (do_write && aw_addr_q[7:2] == pg_diag_pkg::OFS_FAULT[7:2]) ?
		w_data_q[NR-1:0] & wmask[NR-1:0] : '0;

	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			rail_fault_latch_reg_q <= '0;
		else if (ce)
			rail_fault_latch_reg_q <= (rail_fault_latch_reg_q & ~fault_clr) | fault_set;
	end

	a_fault_sticky: assert property (
		rail_fault_latch_reg_q[0] && !fault_clr[0] |=> rail_fault_latch_reg_q[0])
		else $error("rail fault bit dropped without a write of one");

	// ****************************************************************
	// power-good state
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			en_prev_q   <= '0;
			ramp_prev_q <= '0;
			started_q   <= 1'b0;
		end
		else if (ce)
		begin
			en_prev_q   <= rail_enable;
			ramp_prev_q <= ramp_en;
			if (otp_done)
				started_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			hold_cnt_q <= '0;
		else if (ce)
		begin
			if (!cont_mode && hold_trig)
				hold_cnt_q <= HOLD_LOAD;
			else if (hold_cnt_q != '0)
				hold_cnt_q <= hold_cnt_q - 1'b1;
		end
	end

	always_comb
	begin
		pg_d = pg_q;
		if (!started_q)
			pg_d = otp_done;
		else if (cont_mode)
			pg_d = !en_rise && valid_all && !(|ramp_en) &&
				!(ctrl_b_q.fault_holds_pg_inactive && |rail_fault_latch_reg_q);
		else if (!freeze)
			pg_d = valid_all && !(|rail_fault_latch_reg_q) && !(|fault_set);
	end

	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			pg_q           <= 1'b0;
			power_good_out <= 1'b0;
			power_good_oe  <= 1'b1;
		end
		else if (ce)
		begin
			pg_q           <= pg_d;
			power_good_out <= pg_d ~^ ctrl_a_q.pg_pin_polarity;
			// open drain only pulls the pin low
			power_good_oe  <= !ctrl_a_q.pg_pin_open_drain ||
				!(pg_d ~^ ctrl_a_q.pg_pin_polarity);
		end
	end

	sequence s_load_done;
		otp_done && !started_q;
	endsequence

	sequence s_gated_hold;
		started_q && freeze;
	endsequence

	a_load_asserts: assert property (
		s_load_done |=> pg_q ##1 started_q)
		else $error("power-good not asserted after configuration load");

	a_holdoff_freeze: assert property (
		s_gated_hold |=> $stable(pg_q))
		else $error("power-good moved during the hold-off");

	a_pg_needs_valid: assert property (
		pg_q && $past(started_q && !freeze) |-> $past(valid_all))
		else $error("power-good active with an invalid source");

	a_ramp_inactive: assert property (
		started_q && cont_mode && |ramp_en |=> !pg_q)
		else $error("power-good active while a rail ramps");

	a_fault_gates: assert property (
		started_q && cont_mode && ctrl_b_q.fault_holds_pg_inactive
		&& |rail_fault_latch_reg_q |=> !pg_q)
		else $error("fault gating did not hold power-good inactive");

	a_pin_shape: assert property (
		1'b1 |=> (power_good_out == (pg_q ~^ $past(ctrl_a_q.pg_pin_polarity)))
		&& (power_good_oe || $past(ctrl_a_q.pg_pin_open_drain)))
		else $error("power-good pin level or drive type wrong");
endmodule
`default_nettype wire

// File: tb/pg_host_model.sv
`default_nettype none
module pg_host_model (
	// pins from the device
	input  wire logic pg_pin,
	input  wire logic pg_oe,
	input  wire logic irq_n,
	// levels the host sees
	output logic      pg_seen,
	output logic      irq_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************
	// board wiring
	// ************************************************
	// a released pin floats to the board pull-up, never the last value
	assign pg_seen  = pg_oe ? pg_pin : 1'h1;
	assign irq_seen = irq_n;
endmodule
`default_nettype wire

// File: tb/power_good_and_diag_monitor_test.sv
`default_nettype none
module power_good_and_diag_monitor_test;
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************
	// signals and helpers
	// ************************************************
	logic clk = 0, rst_n = 0, ce = 1, otp_done = 0, otp_pg_mode = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 4'hF, en = 0, uv = 0, ov = 4'hF, ramp = 0, lim = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, pg, oe, irq_n, pg_seen, irq_seen;
	logic tlo = 0, thi = 0, ovp = 0, tsd = 0;
	logic [1:0] bresp, rresp;
	logic [1:0][2:0] ilim;
	int error_cnt = 0, checks_done = 0;
	always #5 clk = ~clk;
	power_good_and_diag_monitor #(.HOLDOFF_CYCLES(20)) i_power_good_and_diag_monitor (
		.clk, .ce, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .otp_done, .otp_pg_mode, .rail_enable(en), .rail_uv_ok(uv),
		.rail_ov_ok(ov), .rail_ramping(ramp), .rail_in_limit(lim),
		.temp_above_warn_lo(tlo), .temp_above_warn_hi(thi), .ovp_detect(ovp),
		.tsd_detect(tsd), .power_good_out(pg), .power_good_oe(oe), .irq_line_n(irq_n),
		.buck_peak_limit_setting(ilim));
	pg_host_model i_pg_host_model (.pg_pin(pg), .pg_oe(oe), .irq_n(irq_n),
		.pg_seen(pg_seen), .irq_seen(irq_seen));
	task automatic end_of_test;
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// handshake flags are sampled mid-cycle so the edge updates have landed
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic fa, fw, fb;
		fa = 0;
		fw = 0;
		fb = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int n = 0; n < 200 && !fb; n++)
		begin
			@(negedge clk);
			fa = fa | awready;
			fw = fw | wready;
			fb = bvalid;
			if (fb)
				chk({30'h0, bresp}, {30'h0, er});
			@(posedge clk);
			if (fa && awvalid)
				awvalid <= 1'h0;
			if (fw && wvalid)
				wvalid <= 1'h0;
		end
		if (!fb)
		begin
			error_cnt++;
			end_of_test();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic fa, fr;
		fa = 0;
		fr = 0;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int n = 0; n < 200 && !fr; n++)
		begin
			@(negedge clk);
			fa = fa | arready;
			fr = rvalid;
			if (fr)
				chk(rdata, e);
			if (fr)
				chk({30'h0, rresp}, {30'h0, er});
			@(posedge clk);
			if (fa && arvalid)
				arvalid <= 1'h0;
		end
		if (!fr)
		begin
			error_cnt++;
			end_of_test();
		end
	endtask
	task automatic pins(input int n, input logic p, input logic q);
		repeat (n) @(posedge clk);
		@(negedge clk);
		chk({31'h0, pg_seen}, {31'h0, p});
		chk({31'h0, irq_seen}, {31'h0, q});
		@(posedge clk);
	endtask
	// ************************************************
	// sequence
	// ************************************************
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		rd(8'h00, 32'h100, 2'h0);
		rd(8'h14, 32'h0, 2'h0);
		rd(8'h1C, 32'h0, 2'h2);
		otp_done <= 1'h1;
		pins(3, 1'h1, 1'h1);
		uv <= 4'h7;
		wr(8'h00, 32'h119, 2'h0);
		pins(2, 1'h1, 1'h1);
		ov <= 4'hE;
		en <= 4'h1;
		pins(5, 1'h1, 1'h1);
		pins(30, 1'h0, 1'h1);
		rd(8'h0C, 32'h1, 2'h0);
		ov <= 4'hF;
		pins(5, 1'h0, 1'h1);
		wr(8'h0C, 32'h1, 2'h0);
		pins(2, 1'h1, 1'h1);
		wr(8'h00, 32'h019, 2'h0);
		pins(2, 1'h0, 1'h1);
		wr(8'h00, 32'h319, 2'h0);
		pins(2, 1'h1, 1'h1);
		@(negedge clk);
		chk({31'h0, oe}, 32'h0);
		@(posedge clk);
		ovp <= 1'h1;
		tsd <= 1'h1;
		pins(3, 1'h0, 1'h0);
		wr(8'h10, 32'h60, 2'h0);
		rd(8'h10, 32'h60, 2'h0);
		ovp <= 1'h0;
		tsd <= 1'h0;
		wr(8'h10, 32'h60, 2'h0);
		pins(2, 1'h1, 1'h1);
		lim <= 4'h4;
		pins(1990, 1'h1, 1'h1);
		pins(20, 1'h1, 1'h0);
		wr(8'h10, 32'h4, 2'h0);
		rd(8'h10, 32'h4, 2'h0);
		lim <= 4'h0;
		wr(8'h10, 32'h4, 2'h0);
		pins(2, 1'h1, 1'h1);
		wr(8'h14, 32'h1, 2'h0);
		lim <= 4'h1;
		pins(2010, 1'h1, 1'h1);
		rd(8'h10, 32'h1, 2'h0);
		lim <= 4'h0;
		wr(8'h10, 32'h1, 2'h0);
		wr(8'h04, 32'h1, 2'h0);
		tlo <= 1'h1;
		pins(3, 1'h0, 1'h0);
		wr(8'h10, 32'h10, 2'h0);
		rd(8'h10, 32'h10, 2'h0);
		tlo <= 1'h0;
		wr(8'h10, 32'h10, 2'h0);
		pins(3, 1'h1, 1'h1);
		wr(8'h08, 32'h53, 2'h0);
		chk({26'h0, ilim}, 32'h2B);
		lim <= 4'h2;
		rd(8'h18, 32'h782, 2'h0);
		lim <= 4'h0;
		wr(8'h04, 32'h6, 2'h0);
		ramp <= 4'h1;
		pins(2, 1'h0, 1'h1);
		ramp <= 4'h0;
		pins(2, 1'h1, 1'h1);
		ov <= 4'hE;
		pins(2, 1'h0, 1'h1);
		ov <= 4'hF;
		pins(2, 1'h0, 1'h1);
		wr(8'h04, 32'h2, 2'h0);
		pins(2, 1'h1, 1'h1);
		rd(8'h0C, 32'h1, 2'h0);
		wr(8'h0C, 32'h1, 2'h0);
		en <= 4'h3;
		pins(1, 1'h0, 1'h1);
		pins(1, 1'h1, 1'h1);
		wr(8'h04, 32'hA, 2'h0);
		tlo <= 1'h1;
		pins(3, 1'h1, 1'h1);
		thi <= 1'h1;
		pins(3, 1'h1, 1'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
